// File: pss_map.svh
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// ****************************************
// Register byte offsets.
// ****************************************
`define PSS_OFF_SDCTL 12'h000
`define PSS_OFF_SRCSEL 12'h004
`define PSS_OFF_PINLVL 12'h008
`define PSS_OFF_STEER 12'h00C
`define PSS_OFF_MODE 12'h010
`define PSS_OFF_LOAD 12'h014
`define PSS_OFF_IRQST 12'h018
`define PSS_OFF_IRQMSK 12'h01C
`define PSS_OFF_STATUS 12'h020

// ****************************************
// Shutdown control field positions.
// ****************************************
`define PSS_SD_EVENT_BIT 7
`define PSS_SD_EN_BIT 6
`define PSS_SD_RESTART_BIT 5
`define PSS_SD_OVR_BIT 0
`define PSS_SD_WMASK 8'hE1

// ****************************************
// Interrupt status bit positions.
// ****************************************
`define PSS_IRQ_SHUTDOWN_BIT 0
`define PSS_IRQ_LOADED_BIT 1

// ****************************************
// Reset values.
// ****************************************
`define PSS_RST_SDCTL 8'h00
`define PSS_RST_BYTE 8'h00
`define PSS_RST_MODE 3'h0

`endif

// File: pss_pkg.sv
package pss_pkg;

  // Number of controller output pins and shutdown sources.
  localparam int NPIN = 6;
  localparam int NSRC = 8;

  // Operating mode codes of the PWM controller.
  typedef enum logic [2:0]
  {
    PSS_MODE_OTHER = 3'h0,
    PSS_MODE_SINGLE = 3'h1,
    PSS_MODE_COMPL = 3'h2,
    PSS_MODE_3PH = 3'h3
  } pss_mode_t;

  // AHB-Lite slave request bundle.
  typedef struct packed
  {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } pss_ahb_req_t;

  // AHB-Lite slave answer bundle.
  typedef struct packed
  {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } pss_ahb_rsp_t;

  // Waveform inputs from the PWM generator.
  typedef struct packed
  {
    logic period_evt;
    logic pwm_a;
    logic pwm_b;
    logic [NPIN-1:0] phase3;
  } pss_wave_t;

endpackage : pss_pkg

// File: pss_top.sv
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "pss_map.svh"

module pss_top
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire pss_pkg::pss_ahb_req_t ahb_i,
  output pss_pkg::pss_ahb_rsp_t ahb_o,
  input wire pss_pkg::pss_wave_t wave_i,
  input wire logic [pss_pkg::NSRC-1:0] shutdown_src_i,
  output logic [pss_pkg::NPIN-1:0] pwm_pin_o,
  output logic irq_o
);
  import pss_pkg::*;

  // ****************************************
  // Bus address phase capture.
  // ****************************************

  logic wr_pend_r; // A write data phase follows.
  logic [11:0] wr_addr_r; // Address of that write.
  logic [31:0] rdata_r; // Registered read data.
  logic addr_ok; // Address phase is valid this cycle.
  logic wr_now; // Write data is on the bus this cycle.
  logic [7:0] wd; // Low byte of the write data.

  assign addr_ok = ce_i && ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
  assign wr_now = ce_i && wr_pend_r;
  assign wd = ahb_i.hwdata[7:0];

  // Answers are zero wait state and always OKAY.
  assign ahb_o.hreadyout = 1'b1;
  assign ahb_o.hresp = 1'b0;
  assign ahb_o.hrdata = rdata_r;

  // ****************************************
  // Registers.
  // ****************************************

  logic [7:0] sdctl_r; // Shutdown control.
  logic [NSRC-1:0] srcsel_r; // Shutdown source select.
  logic [NPIN-1:0] pinlvl_r; // Shutdown pin levels.
  logic [NPIN-1:0] steer_pend_r; // Steering written by software.
  logic [NPIN-1:0] steer_act_r; // Steering in force at the pins.
  logic sync_steer_r; // Synchronized steering selected.
  logic [2:0] mode_r; // Operating mode code.
  logic load_req_r; // Period load request.
  logic [1:0] irq_st_r; // Sticky interrupt status.
  logic [1:0] irq_msk_r; // Interrupt mask.

  // Tracks write data phases and latches their address.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end
    else if (ce_i)
    begin
      wr_pend_r <= addr_ok && ahb_i.hwrite;
      wr_addr_r <= ahb_i.haddr[11:0];
    end
  end

  // ****************************************
  // Shutdown source synchronizer.
  // ****************************************

  logic [NSRC-1:0] src_s1_r; // First stage, read only by stage two.
  logic [NSRC-1:0] src_s2_r; // Second stage, safe to evaluate.

  // Two flip-flops per source before any logic sees it.
  generate
    for (genvar g = 0; g < NSRC; g++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
        begin
          src_s1_r[g] <= 1'b0;
          src_s2_r[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          src_s1_r[g] <= shutdown_src_i[g];
          src_s2_r[g] <= src_s1_r[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Auto-shutdown decisions.
  // ****************************************

  logic sd_en; // Auto-shutdown enabled.
  logic src_hit; // A selected source reads one.
  logic sd_trip; // Hardware shutdown event this cycle.
  logic sw_set_evt; // Software writes one to the event flag.
  logic sw_clr_evt; // Software writes zero to the event flag.
  logic force_lvl; // Pins take their shutdown levels.

  assign sd_en = sdctl_r[`PSS_SD_EN_BIT];
  assign src_hit = |(src_s2_r & srcsel_r);
  assign sd_trip = ce_i && sd_en && src_hit;
  assign sw_set_evt = wr_now && (wr_addr_r == `PSS_OFF_SDCTL) && wd[`PSS_SD_EVENT_BIT];
  assign sw_clr_evt = wr_now && (wr_addr_r == `PSS_OFF_SDCTL) && !wd[`PSS_SD_EVENT_BIT];
  // Event flag forces like a trip; override forces only while enabled.
  assign force_lvl = sdctl_r[`PSS_SD_EVENT_BIT] ||
    (sd_en && sdctl_r[`PSS_SD_OVR_BIT]);

  // Shutdown control register and its event flag.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sdctl_r <= `PSS_RST_SDCTL;
    end
    else if (ce_i)
    begin
      if (wr_now && (wr_addr_r == `PSS_OFF_SDCTL))
      begin
        // Writable bits take the new value; the flag is handled below.
        sdctl_r[`PSS_SD_EN_BIT] <= wd[`PSS_SD_EN_BIT];
        sdctl_r[`PSS_SD_RESTART_BIT] <= wd[`PSS_SD_RESTART_BIT];
        sdctl_r[`PSS_SD_OVR_BIT] <= wd[`PSS_SD_OVR_BIT];
      end
      if (sd_trip || sw_set_evt)
      begin
        // A trip wins over a firmware clear in the same cycle.
        sdctl_r[`PSS_SD_EVENT_BIT] <= 1'b1;
      end
      else if (sdctl_r[`PSS_SD_EVENT_BIT] && sdctl_r[`PSS_SD_RESTART_BIT])
      begin
        // Source has gone: resume on its own.
        sdctl_r[`PSS_SD_EVENT_BIT] <= 1'b0;
      end
      else if (sw_clr_evt)
      begin
        // Firmware restart after the condition is gone.
        sdctl_r[`PSS_SD_EVENT_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Plain configuration registers.
  // ****************************************

  // Source select, shutdown levels, mode and steering written by software.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      srcsel_r <= `PSS_RST_BYTE;
      pinlvl_r <= NPIN'(`PSS_RST_BYTE);
      mode_r <= `PSS_RST_MODE;
      steer_pend_r <= NPIN'(`PSS_RST_BYTE);
      sync_steer_r <= 1'b0;
      irq_msk_r <= 2'h0;
    end
    else if (wr_now)
    begin
      unique case (wr_addr_r)
        `PSS_OFF_SRCSEL: srcsel_r <= wd;
        `PSS_OFF_PINLVL: pinlvl_r <= wd[NPIN-1:0];
        `PSS_OFF_MODE: mode_r <= wd[2:0];
        `PSS_OFF_STEER:
        begin
          // Bit 7 picks synchronized steering, low bits one enable per pin.
          steer_pend_r <= wd[NPIN-1:0];
          sync_steer_r <= wd[7];
        end
        `PSS_OFF_IRQMSK: irq_msk_r <= wd[1:0];
        default:
        begin
          // Other addresses hold no plain configuration.
        end
      endcase
    end
  end

  // ****************************************
  // Steering update timing.
  // ****************************************

  logic load_set; // Software sets the load request.
  logic load_fire; // Pending steering moves to the pins.

  assign load_set = wr_now && (wr_addr_r == `PSS_OFF_LOAD) && wd[0];
  assign load_fire = ce_i && load_req_r && wave_i.period_evt;

  // Load request stays set until the next period event takes it.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      load_req_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (load_set)
      begin
        load_req_r <= 1'b1;
      end
      else if (load_fire)
      begin
        load_req_r <= 1'b0;
      end
    end
  end

  // Active steering follows software at once or at the period event.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      steer_act_r <= NPIN'(`PSS_RST_BYTE);
    end
    else if (ce_i)
    begin
      if (!sync_steer_r)
      begin
        steer_act_r <= steer_pend_r;
      end
      else if (load_fire)
      begin
        steer_act_r <= steer_pend_r;
      end
    end
  end

  // ****************************************
  // Output pin formation.
  // ****************************************

  logic [NPIN-1:0] pin_nxt; // Pin values before registering.

  // Picks the waveform per pin by mode, then applies shutdown forcing.
  always_comb
  begin
    pin_nxt = '0;
    for (int i = 0; i < NPIN; i++)
    begin
      unique case (mode_r)
        PSS_MODE_SINGLE: pin_nxt[i] = steer_act_r[i] & wave_i.pwm_a;
        PSS_MODE_COMPL: pin_nxt[i] = steer_act_r[i] &
          ((i % 2 == 0) ? wave_i.pwm_a : wave_i.pwm_b);
        PSS_MODE_3PH: pin_nxt[i] = steer_act_r[i] & wave_i.phase3[i];
        default: pin_nxt[i] = (i == 0) ? wave_i.pwm_a : 1'b0;
      endcase
      if (force_lvl)
      begin
        pin_nxt[i] = pinlvl_r[i];
      end
    end
  end

  // Pins are registered so they change on one clock edge.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pwm_pin_o <= NPIN'(`PSS_RST_BYTE);
    end
    else if (ce_i)
    begin
      pwm_pin_o <= pin_nxt;
    end
  end

  // ****************************************
  // Interrupts.
  // ****************************************

  logic [1:0] irq_ev; // Events this cycle.
  logic [1:0] irq_w1c; // Bits software clears.

  // A trip or a software write of one to the event flag raises the shutdown interrupt, never the override.
  assign irq_ev = {load_fire, sd_trip || (ce_i && sw_set_evt)};
  assign irq_w1c = (wr_now && (wr_addr_r == `PSS_OFF_IRQST)) ? wd[1:0] : 2'h0;

  // Sticky status, set beats clear.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_st_r <= 2'h0;
    end
    else if (ce_i)
    begin
      irq_st_r <= (irq_st_r & ~irq_w1c) | irq_ev;
    end
  end

  // Level output from a register.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_o <= |(((irq_st_r & ~irq_w1c) | irq_ev) & irq_msk_r);
    end
  end

  // ****************************************
  // Read data.
  // ****************************************

  // Read data latched at the address phase; unmapped reads give zero.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (addr_ok && !ahb_i.hwrite)
    begin
      unique case (ahb_i.haddr[11:0])
        `PSS_OFF_SDCTL: rdata_r <= {24'h0, sdctl_r & `PSS_SD_WMASK};
        `PSS_OFF_SRCSEL: rdata_r <= {24'h0, srcsel_r};
        `PSS_OFF_PINLVL: rdata_r <= {26'h0, pinlvl_r};
        `PSS_OFF_STEER: rdata_r <= {24'h0, sync_steer_r, 1'b0, steer_pend_r};
        `PSS_OFF_MODE: rdata_r <= {29'h0, mode_r};
        `PSS_OFF_LOAD: rdata_r <= {31'h0, load_req_r};
        `PSS_OFF_IRQST: rdata_r <= {30'h0, irq_st_r};
        `PSS_OFF_IRQMSK: rdata_r <= {30'h0, irq_msk_r};
        `PSS_OFF_STATUS: rdata_r <= {15'h0000, force_lvl, src_s2_r, 2'h0, steer_act_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

endmodule : pss_top

// File: pss_gate_model.sv
`timescale 1ns/100ps
// Gate driver stage: each power switch follows its pin level.
module pss_gate_model
(
  input wire logic [pss_pkg::NPIN-1:0] pin_i,
  output logic [pss_pkg::NPIN-1:0] gate_o
);
  import pss_pkg::*;
  assign gate_o = pin_i;
endmodule : pss_gate_model

// File: pss_properties.sv
`timescale 1ns/100ps
`include "pss_map.svh"
module pss_checker
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire pss_pkg::pss_ahb_req_t ahb_i,
  input wire pss_pkg::pss_ahb_rsp_t ahb_o,
  input wire pss_pkg::pss_wave_t wave_i,
  input wire logic [pss_pkg::NSRC-1:0] shutdown_src_i,
  input wire logic [pss_pkg::NPIN-1:0] pwm_pin_o,
  input wire logic irq_o
);
  import pss_pkg::*;
  logic [11:0] wa_r;
  logic [7:0] sd_r, sel_r, st_r;
  logic [5:0] lvl_r, ex;
  logic [2:0] md_r;
  logic wv_r, trip, calm;
  logic [32:0] cfg, cfg_d;
  // Shadow of the written setup, so expectations need no register reads.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {wv_r, wa_r, sd_r, sel_r, st_r, lvl_r, md_r} <= '0;
    end
    else if (ce_i)
    begin
      wv_r <= ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1] && ahb_i.hwrite;
      wa_r <= ahb_i.haddr[11:0];
      if (wv_r)
      begin
        case (wa_r)
          `PSS_OFF_SDCTL: sd_r <= ahb_i.hwdata[7:0] & 8'h61;
          `PSS_OFF_SRCSEL: sel_r <= ahb_i.hwdata[7:0];
          `PSS_OFF_PINLVL: lvl_r <= ahb_i.hwdata[5:0];
          `PSS_OFF_STEER: st_r <= ahb_i.hwdata[7:0];
          `PSS_OFF_MODE: md_r <= ahb_i.hwdata[2:0];
          default: ;
        endcase
      end
    end
  end
  // One cycle old copy, to see when the setup has settled.
  always_ff @(posedge clk_i)
  begin
    cfg_d <= cfg;
  end
  assign cfg = {sd_r, sel_r, st_r, lvl_r, md_r};
  assign calm = ce_i && !wv_r && (cfg == cfg_d);
  assign trip = sd_r[6] && |(shutdown_src_i & sel_r);
  // Pin pattern expected in normal running.
  always_comb
  begin
    case (md_r)
      PSS_MODE_SINGLE: ex = st_r[5:0] & {6{wave_i.pwm_a}};
      PSS_MODE_COMPL: ex = st_r[5:0] & {3{wave_i.pwm_b, wave_i.pwm_a}};
      PSS_MODE_3PH: ex = st_r[5:0] & wave_i.phase3;
      default: ex = {5'h00, wave_i.pwm_a};
    endcase
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_other;
    (calm && !sd_r[6] && md_r == 3'h0) [*3] |=> pwm_pin_o == $past(ex);
  endproperty
  a_other: assert property (p_other) else $error("unsteered pins wrong");
  property p_single;
    (calm && !sd_r[6] && !st_r[7] && md_r == 3'h1) [*3] |=> pwm_pin_o == $past(ex);
  endproperty
  a_single: assert property (p_single) else $error("single pins wrong");
  property p_compl;
    (calm && !sd_r[6] && !st_r[7] && md_r == 3'h2) [*3] |=> pwm_pin_o == $past(ex);
  endproperty
  a_compl: assert property (p_compl) else $error("pair pins wrong");
  property p_three;
    (calm && !sd_r[6] && !st_r[7] && md_r == 3'h3) [*3] |=> pwm_pin_o == $past(ex);
  endproperty
  a_three: assert property (p_three) else $error("phase pins wrong");
  property p_trip;
    (calm && trip) [*5] |=> pwm_pin_o == lvl_r;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not forced");
  property p_ovr;
    (calm && sd_r[6] && sd_r[0]) [*2] |=> pwm_pin_o == lvl_r;
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not forced");
  property p_restart;
    (calm && sd_r[6] && sd_r[5] && !sd_r[0] && !trip && md_r == 3'h0) [*5]
      |=> pwm_pin_o == $past(ex);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_latch;
    (calm && trip && !sd_r[5]) [*5] ##1 (calm && sd_r[6] && !sd_r[5]) [*3]
      |=> pwm_pin_o == lvl_r;
  endproperty
  a_latch: assert property (p_latch) else $error("shutdown not held");
  c_trip: cover property (trip ##6 pwm_pin_o == lvl_r);
  c_ovr: cover property (sd_r[6] && sd_r[0] && calm);
  c_sync: cover property (st_r[7] && wave_i.period_evt);
endmodule : pss_checker
bind pss_top pss_checker i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .ahb_i(ahb_i), .ahb_o(ahb_o), .wave_i(wave_i), .shutdown_src_i(shutdown_src_i),
  .pwm_pin_o(pwm_pin_o), .irq_o(irq_o));

// File: pwm_steering_autoshutdown_bench.sv
`timescale 1ns/100ps
`include "pss_map.svh"
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module pwm_steering_autoshutdown_bench;
  import pss_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic busy = 1'b0;
  logic ce = 1'b1;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  pss_wave_t wave = '0;
  logic [NSRC-1:0] src = '0;
  pss_ahb_req_t req;
  pss_ahb_rsp_t rsp;
  logic [NPIN-1:0] pins, gate;
  logic irq;
  int errors = 0;
  int checks = 0;
  assign req = '{1'b1, haddr, {busy, 1'b0}, hwrite, 3'h2, rsp.hreadyout, hwdata};
  always #5 clk_i = ~clk_i;
  pss_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .ahb_i(req),
    .ahb_o(rsp), .wave_i(wave), .shutdown_src_i(src), .pwm_pin_o(pins), .irq_o(irq));
  pss_gate_model i_gate (.pin_i(pins), .gate_o(gate));
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // Waits, with a bound, for ready sampled high at a rising edge.
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rsp.hreadyout !== 1'b1 && n < 32);
    if (rsp.hreadyout !== 1'b1)
    begin
      errors++;
      final_report();
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    busy <= 1'b1;
    hwrite <= w;
    haddr <= {20'h00000, a};
    wait_rdy();
    busy <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = rsp.hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'h000000, d}, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    `CHK(q, {24'h000000, e})
    `CHK(rsp.hresp, 1'b0)
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  task automatic t_steer;
    logic [5:0] ex [5];
    ex = '{6'h01, 6'h3C, 6'h14, 6'h2C, 6'h01};
    rd(`PSS_OFF_SDCTL, 8'h00);
    wr(`PSS_OFF_SDCTL, 8'h1E);
    rd(`PSS_OFF_SDCTL, 8'h00);
    rd(12'h040, 8'h00);
    wave <= '{1'b0, 1'b1, 1'b0, 6'h2D};
    wr(`PSS_OFF_STEER, 8'h3C);
    for (int m = 0; m < 5; m++)
    begin
      wr(`PSS_OFF_MODE, 8'(m));
      idle(6);
      `CHK(gate, ex[m])
    end
    wr(`PSS_OFF_MODE, 8'h01);
    wr(`PSS_OFF_STEER, 8'h83);
    wr(`PSS_OFF_LOAD, 8'h01);
    rd(`PSS_OFF_LOAD, 8'h01);
    idle(6);
    `CHK(gate, 6'h3C)
    wave.period_evt <= 1'b1;
    idle(1);
    wave.period_evt <= 1'b0;
    idle(4);
    `CHK(gate, 6'h03)
    rd(`PSS_OFF_STATUS, 8'h03);
    rd(`PSS_OFF_IRQST, 8'h02);
    wr(`PSS_OFF_IRQST, 8'h02);
    wr(`PSS_OFF_MODE, 8'h00);
    $display("steer test done");
  endtask : t_steer
  task automatic t_shut;
    wr(`PSS_OFF_SRCSEL, 8'h04);
    wr(`PSS_OFF_PINLVL, 8'h2A);
    wr(`PSS_OFF_IRQMSK, 8'h01);
    wr(`PSS_OFF_SDCTL, 8'h40);
    src <= 8'h04;
    idle(6);
    `CHK(gate, 6'h2A)
    `CHK(irq, 1'b1)
    rd(`PSS_OFF_SDCTL, 8'hC0);
    src <= 8'h00;
    idle(6);
    `CHK(gate, 6'h2A)
    wr(`PSS_OFF_SDCTL, 8'h40);
    wr(`PSS_OFF_IRQST, 8'h01);
    idle(4);
    `CHK(gate, 6'h01)
    `CHK(irq, 1'b0)
    wr(`PSS_OFF_IRQMSK, 8'h00);
    wr(`PSS_OFF_SDCTL, 8'h60);
    wr(`PSS_OFF_SDCTL, 8'hE0);
    idle(4);
    `CHK(gate, 6'h01)
    `CHK(irq, 1'b0)
    rd(`PSS_OFF_IRQST, 8'h01);
    wr(`PSS_OFF_IRQMSK, 8'h01);
    idle(2);
    `CHK(irq, 1'b1)
    wr(`PSS_OFF_IRQST, 8'h01);
    wr(`PSS_OFF_SDCTL, 8'h41);
    idle(4);
    `CHK(gate, 6'h2A)
    `CHK(irq, 1'b0)
    wr(`PSS_OFF_SDCTL, 8'h01);
    idle(4);
    `CHK(gate, 6'h01)
    ce <= 1'b0;
    wave.pwm_a <= 1'b0;
    idle(4);
    `CHK(gate, 6'h01)
    ce <= 1'b1;
    idle(3);
    `CHK(gate, 6'h00)
    $display("shutdown test done");
  endtask : t_shut
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_steer();
    t_shut();
    final_report();
  end
endmodule : pwm_steering_autoshutdown_bench
